/* synth_serial_pkg.sv */
// Constants, word layouts and types for the serial programming port
`default_nettype none

package synth_serial_pkg;

  // ----------------------------------------------------------------
  // Word framing
  // ----------------------------------------------------------------
  localparam int WORD_W      = 24;
  localparam int MAIN_FLAG   = 23;
  localparam int ADDR_W      = 4;
  localparam int ADDR_LSB    = 20;
  localparam int TEST_W      = 19;
  localparam int SYNC_STAGES = 2;

  localparam logic [ADDR_W-1:0] ADDR_GENERAL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_REFERENCE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_AUXILIARY = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_PUMP      = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_TEST      = 4'h4;

  // ----------------------------------------------------------------
  // Payload layouts, first field is the most significant
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  fractional_increment;
    logic [7:0]  upper_counts;
    logic [11:0] main_first_cycle_count;
  } main_word_s;

  typedef struct packed {
    logic        fraction_modulus_flag;
    logic [1:0]  prescaler_select;
    logic [3:0]  integral_accel_factor;
    logic [1:0]  proportional_accel_factor;
    logic [7:0]  pump_current_factor;
  } pump_word_s;

  typedef struct packed {
    logic [12:0] aux_ratio;
    logic        enhanced_scheme_bit;
  } aux_word_s;

  typedef struct packed {
    logic        aux_divider_enable;
    logic        main_divider_enable;
    logic [1:0]  aux_ref_select;
    logic [1:0]  main_ref_select;
    logic [11:0] reference_ratio;
  } ref_word_s;

  typedef struct packed {
    logic        sleep_bit;
    logic        digital_cellular;
    logic        transmit_if_loop_enable;
    logic [1:0]  transmit_if_div_select;
    logic [6:0]  gain_power_control;
  } general_word_s;

  // Main divider counts after prescaler-dependent split
  typedef struct packed {
    logic        dual_modulus;
    logic [11:0] main_first_cycle_count;
    logic [7:0]  main_second_cycle_count;
    logic [3:0]  main_third_cycle_count;
    logic [2:0]  fractional_increment;
    logic        fraction_modulus_flag;
  } main_div_s;

  localparam int MAIN_W = $bits(main_word_s);
  localparam int PUMP_W = $bits(pump_word_s);
  localparam int AUX_W  = $bits(aux_word_s);
  localparam int REF_W  = $bits(ref_word_s);
  localparam int GEN_W  = $bits(general_word_s);

  localparam main_word_s    MAIN_RESET = '0;
  localparam pump_word_s    PUMP_RESET = '0;
  localparam aux_word_s     AUX_RESET  = '0;
  localparam ref_word_s     REF_RESET  = '0;
  localparam general_word_s GEN_RESET  = '0;
  localparam logic [TEST_W-1:0] TEST_RESET = 19'h00000;

  localparam logic [3:0] TRANSMIT_IF_RATIO_BASE = 4'h6;

  typedef enum logic [3:0] {
    PM_SLEEP    = 4'b0001,
    PM_STANDBY  = 4'b0010,
    PM_TRANSMIT = 4'b0100,
    PM_OTHER    = 4'b1000
  } power_mode_e;

endpackage

`default_nettype wire

/* synth_serial_program_port.sv */
// Three-wire serial programming port with working and temporary registers
`default_nettype none


module synth_serial_program_port #(
  parameter int SYNC_DEPTH = synth_serial_pkg::SYNC_STAGES
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  input  wire logic                            clk_en,
  input  wire logic                            serial_clk,
  input  wire logic                            serial_data,
  input  wire logic                            latch_strobe,
  input  wire logic                            main_sync,
  output logic                                 main_word_pending,
  output synth_serial_pkg::main_div_s          main_div,
  output synth_serial_pkg::pump_word_s         pump_cfg,
  output synth_serial_pkg::aux_word_s          aux_cfg,
  output synth_serial_pkg::ref_word_s          ref_cfg,
  output synth_serial_pkg::general_word_s      general_cfg,
  output logic [synth_serial_pkg::TEST_W-1:0]  test_route,
  output logic                                 ref_buffer_enable,
  output logic [3:0]                           main_ref_post_div,
  output logic [3:0]                           aux_ref_post_div,
  output logic [3:0]                           transmit_if_ratio,
  output logic                                 transmit_if_synth_on,
  output logic                                 synth_shutdown,
  output logic                                 digital_cellular,
  output logic                                 analog_cellular,
  output logic                                 enhanced_mode,
  output synth_serial_pkg::power_mode_e        power_mode
);
  import synth_serial_pkg::*;

  // Fewer than two stages would hand a metastable strobe to the decode
  if (SYNC_DEPTH < 2) begin : g_sync_depth_check
    $error("SYNC_DEPTH must be at least 2");
  end

  // ----------------------------------------------------------------
  // Link domain: input shift register
  // ----------------------------------------------------------------
  // No reset here: the serial clock may stand still during reset, and
  // the contents are only read after a full word and a strobe edge.
  logic [WORD_W-1:0] shift_word;
  logic [WORD_W-1:0] next_shift_word;

  always_comb begin
    next_shift_word = shift_word;
    if (!latch_strobe) begin
      next_shift_word = {serial_data, shift_word[WORD_W-1:1]};
    end
  end

  always_ff @(posedge serial_clk) begin
    shift_word <= next_shift_word;
  end

  // ----------------------------------------------------------------
  // System domain: strobe synchroniser and edge detect
  // ----------------------------------------------------------------
  // Shift word is frozen while the strobe is high, so it can be read
  // safely once the synchronised strobe shows the rise.
  logic [SYNC_DEPTH-1:0]  strobe_sync;
  logic [SYNC_DEPTH-1:0]  next_strobe_sync;
  logic                   strobe_last;
  logic                   next_strobe_last;
  logic                   strobe_rise;

  always_comb begin
    next_strobe_sync = {strobe_sync[SYNC_DEPTH-2:0], latch_strobe};
    next_strobe_last = strobe_sync[SYNC_DEPTH-1];
  end

  // Reset to high so an idle strobe gives no false edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strobe_sync <= '1;
      strobe_last <= 1'b1;
    end else if (clk_en) begin
      strobe_sync <= next_strobe_sync;
      strobe_last <= next_strobe_last;
    end
  end

  assign strobe_rise = strobe_sync[SYNC_DEPTH-1] & ~strobe_last;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic              is_main;
  logic [ADDR_W-1:0] word_addr;
  logic              wr_main;
  logic              wr_pump;
  logic              wr_aux;
  logic              wr_ref;
  logic              wr_gen;
  logic              wr_test;

  always_comb begin
    is_main   = shift_word[MAIN_FLAG];
    word_addr = shift_word[ADDR_LSB +: ADDR_W];
    wr_main   = strobe_rise & is_main;
    wr_gen    = 1'b0;
    wr_ref    = 1'b0;
    wr_aux    = 1'b0;
    wr_pump   = 1'b0;
    wr_test   = 1'b0;
    if (strobe_rise && !is_main) begin
      case (word_addr)
        ADDR_GENERAL:   wr_gen  = 1'b1;
        ADDR_REFERENCE: wr_ref  = 1'b1;
        ADDR_AUXILIARY: wr_aux  = 1'b1;
        ADDR_PUMP:      wr_pump = 1'b1;
        ADDR_TEST:      wr_test = 1'b1;
        default: begin
          // Unmapped address: every write enable stays low
          wr_test = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Working and temporary registers
  // ----------------------------------------------------------------
  main_word_s        main_hold;
  main_word_s        main_work;
  pump_word_s        pump_hold;
  pump_word_s        pump_work;
  aux_word_s         aux_work;
  ref_word_s         ref_work;
  general_word_s     gen_work;
  logic [TEST_W-1:0] test_work;
  logic              pending;

  main_word_s        next_main_hold;
  main_word_s        next_main_work;
  pump_word_s        next_pump_hold;
  pump_word_s        next_pump_work;
  aux_word_s         next_aux_work;
  ref_word_s         next_ref_work;
  general_word_s     next_gen_work;
  logic [TEST_W-1:0] next_test_work;
  logic              next_pending;
  logic              do_transfer;

  always_comb begin
    next_main_hold = main_hold;
    next_main_work = main_work;
    next_pump_hold = pump_hold;
    next_pump_work = pump_work;
    next_aux_work  = aux_work;
    next_ref_work  = ref_work;
    next_gen_work  = gen_work;
    next_test_work = test_work;
    next_pending   = pending;

    // Held main word and pump temporaries move together on sync
    do_transfer = pending & main_sync;
    if (do_transfer) begin
      next_main_work = main_hold;
      next_pump_work.pump_current_factor = pump_hold.pump_current_factor;
      next_pump_work.prescaler_select    = pump_hold.prescaler_select;
      next_pending   = 1'b0;
    end

    // A new main word in the transfer cycle wins over the clear
    if (wr_main) begin
      next_main_hold = main_word_s'(shift_word[MAIN_W-1:0]);
      next_pending   = 1'b1;
    end

    if (wr_pump) begin
      next_pump_hold = pump_word_s'(shift_word[PUMP_W-1:0]);
      next_pump_work.proportional_accel_factor =
        next_pump_hold.proportional_accel_factor;
      next_pump_work.integral_accel_factor =
        next_pump_hold.integral_accel_factor;
      next_pump_work.fraction_modulus_flag =
        next_pump_hold.fraction_modulus_flag;
    end

    if (wr_aux) begin
      next_aux_work = aux_word_s'(shift_word[AUX_W-1:0]);
    end

    if (wr_ref) begin
      next_ref_work  = ref_word_s'(shift_word[REF_W-1:0]);
      next_test_work = TEST_RESET;
    end

    if (wr_gen) begin
      next_gen_work = general_word_s'(shift_word[GEN_W-1:0]);
    end

    if (wr_test) begin
      next_test_work = shift_word[TEST_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      main_hold <= MAIN_RESET;
      main_work <= MAIN_RESET;
      pump_hold <= PUMP_RESET;
      pump_work <= PUMP_RESET;
      aux_work  <= AUX_RESET;
      ref_work  <= REF_RESET;
      gen_work  <= GEN_RESET;
      test_work <= TEST_RESET;
      pending   <= 1'b0;
    end else if (clk_en) begin
      main_hold <= next_main_hold;
      main_work <= next_main_work;
      pump_hold <= next_pump_hold;
      pump_work <= next_pump_work;
      aux_work  <= next_aux_work;
      ref_work  <= next_ref_work;
      gen_work  <= next_gen_work;
      test_work <= next_test_work;
      pending   <= next_pending;
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls, registered alongside the working registers
  // ----------------------------------------------------------------
  // Decoded from the values the working registers take at this edge,
  // so every output moves in the same cycle as its register.
  main_word_s    src_main;
  pump_word_s    src_pump;
  aux_word_s     src_aux;
  ref_word_s     src_ref;
  general_word_s src_gen;
  logic          dual_mod;
  logic          en_all;
  logic          en_none;
  main_div_s     next_main_div;
  logic          next_ref_buffer_enable;
  logic [3:0]    next_main_ref_post_div;
  logic [3:0]    next_aux_ref_post_div;
  logic [3:0]    next_transmit_if_ratio;
  logic          next_transmit_if_synth_on;
  logic          next_synth_shutdown;
  logic          next_digital_cellular;
  logic          next_analog_cellular;
  logic          next_enhanced_mode;
  power_mode_e   next_power_mode;

  always_comb begin
    src_main = rst ? MAIN_RESET : next_main_work;
    src_pump = rst ? PUMP_RESET : next_pump_work;
    src_aux  = rst ? AUX_RESET  : next_aux_work;
    src_ref  = rst ? REF_RESET  : next_ref_work;
    src_gen  = rst ? GEN_RESET  : next_gen_work;

    dual_mod = src_pump.prescaler_select[0];

    next_main_div.dual_modulus           = dual_mod;
    next_main_div.main_first_cycle_count = src_main.main_first_cycle_count;
    if (dual_mod) begin
      next_main_div.main_second_cycle_count = src_main.upper_counts;
      next_main_div.main_third_cycle_count  = 4'h0;
    end else begin
      next_main_div.main_second_cycle_count = {4'h0, src_main.upper_counts[3:0]};
      next_main_div.main_third_cycle_count  = src_main.upper_counts[7:4];
    end
    next_main_div.fractional_increment  = src_main.fractional_increment;
    next_main_div.fraction_modulus_flag = src_pump.fraction_modulus_flag;

    next_ref_buffer_enable = src_ref.main_divider_enable
                           | src_ref.aux_divider_enable;
    next_main_ref_post_div = 4'h1 << src_ref.main_ref_select;
    next_aux_ref_post_div  = 4'h1 << src_ref.aux_ref_select;

    next_transmit_if_ratio    = TRANSMIT_IF_RATIO_BASE + {2'b00, src_gen.transmit_if_div_select};
    next_transmit_if_synth_on = src_gen.transmit_if_loop_enable;

    next_digital_cellular = src_gen.digital_cellular;
    next_analog_cellular  = ~src_gen.digital_cellular;
    next_enhanced_mode    = src_aux.enhanced_scheme_bit;

    en_all  = src_gen.sleep_bit & src_ref.main_divider_enable
            & src_ref.aux_divider_enable;
    en_none = ~src_gen.sleep_bit & ~src_gen.transmit_if_loop_enable
            & ~src_ref.main_divider_enable & ~src_ref.aux_divider_enable;

    // Sleep bit is active low: zero shuts the synthesizers down
    if (en_none) begin
      next_power_mode = PM_SLEEP;
    end else if (en_all && !src_gen.transmit_if_loop_enable) begin
      next_power_mode = PM_STANDBY;
    end else if (en_all && src_gen.transmit_if_loop_enable) begin
      next_power_mode = PM_TRANSMIT;
    end else begin
      next_power_mode = PM_OTHER;
    end
    next_synth_shutdown = ~src_gen.sleep_bit;
  end

  // Reset reaches these through the source select, even with clk_en low
  always_ff @(posedge clk_sys) begin
    if (rst || clk_en) begin
      main_div          <= next_main_div;
      ref_buffer_enable <= next_ref_buffer_enable;
      main_ref_post_div <= next_main_ref_post_div;
      aux_ref_post_div  <= next_aux_ref_post_div;
      transmit_if_ratio        <= next_transmit_if_ratio;
      transmit_if_synth_on     <= next_transmit_if_synth_on;
      synth_shutdown    <= next_synth_shutdown;
      digital_cellular  <= next_digital_cellular;
      analog_cellular   <= next_analog_cellular;
      enhanced_mode     <= next_enhanced_mode;
      power_mode        <= next_power_mode;
    end
  end

  assign main_word_pending = pending;
  assign pump_cfg          = pump_work;
  assign aux_cfg           = aux_work;
  assign ref_cfg           = ref_work;
  assign general_cfg       = gen_work;
  assign test_route        = test_work;

endmodule // synth_serial_program_port

`default_nettype wire

/* synth_serial_checker_assertions.sv */
// Concurrent checks on the serial programming port outputs
`default_nettype none

module synth_serial_checker
  import synth_serial_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire logic          clk_en,
  input wire logic          main_sync,
  input wire logic          main_word_pending,
  input wire main_div_s     main_div,
  input wire pump_word_s    pump_cfg,
  input wire aux_word_s     aux_cfg,
  input wire ref_word_s     ref_cfg,
  input wire general_word_s general_cfg,
  input wire logic          ref_buffer_enable,
  input wire logic [3:0]    main_ref_post_div,
  input wire logic [3:0]    aux_ref_post_div,
  input wire logic [3:0]    transmit_if_ratio,
  input wire logic          transmit_if_synth_on,
  input wire logic          synth_shutdown,
  input wire logic          digital_cellular,
  input wire logic          analog_cellular,
  input wire logic          enhanced_mode,
  input wire power_mode_e   power_mode
);
  // ----------------------------------------------------------------
  // Decode and transfer checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic xfer;
  logic [3:0] pbits;
  assign xfer = main_word_pending & main_sync & clk_en;
  assign pbits = {general_cfg.sleep_bit, general_cfg.transmit_if_loop_enable, ref_cfg.aux_divider_enable,
                  ref_cfg.main_divider_enable};

  AST_BUF_EN: assert property (
    ref_buffer_enable == (ref_cfg.main_divider_enable | ref_cfg.aux_divider_enable)) else $error("buffer enable");
  AST_POST_DIV: assert property (
    main_ref_post_div == (4'h1 << ref_cfg.main_ref_select) && aux_ref_post_div == (4'h1 << ref_cfg.aux_ref_select))
    else $error("post divider");
  AST_TRANSMIT_IF_RATIO: assert property (
    transmit_if_ratio == 4'h6 + general_cfg.transmit_if_div_select) else $error("transmit_if ratio");
  AST_SYSTEM: assert property (
    digital_cellular == general_cfg.digital_cellular && analog_cellular != digital_cellular
    && enhanced_mode == aux_cfg.enhanced_scheme_bit) else $error("system select");
  AST_POWER_CTL: assert property (
    transmit_if_synth_on == general_cfg.transmit_if_loop_enable && synth_shutdown != general_cfg.sleep_bit) else $error("power ctl");
  AST_POWER_MODE: assert property (
    power_mode == (pbits == 4'h0 ? PM_SLEEP : pbits == 4'hb ? PM_STANDBY : pbits == 4'hf ? PM_TRANSMIT : PM_OTHER))
    else $error("mode");
  AST_MAIN_HOLD: assert property (
    !xfer |=> $stable({main_div.dual_modulus, main_div.main_first_cycle_count, main_div.main_second_cycle_count,
    main_div.main_third_cycle_count, main_div.fractional_increment})) else $error("main divider moved without sync");
  AST_PUMP_HOLD: assert property (
    !xfer |=> $stable(pump_cfg.pump_current_factor) && $stable(pump_cfg.prescaler_select)) else $error("pump temp");
  AST_SPLIT: assert property (
    main_div.dual_modulus == pump_cfg.prescaler_select[0] && (main_div.dual_modulus ?
    main_div.main_third_cycle_count == 4'h0 : main_div.main_second_cycle_count[7:4] == 4'h0)) else $error("split");
endmodule // synth_serial_checker

bind synth_serial_program_port synth_serial_checker chk (.clk_sys, .rst, .clk_en, .main_sync, .main_word_pending,
  .main_div, .pump_cfg, .aux_cfg, .ref_cfg, .general_cfg, .ref_buffer_enable, .main_ref_post_div, .aux_ref_post_div,
  .transmit_if_ratio, .transmit_if_synth_on, .synth_shutdown, .digital_cellular, .analog_cellular, .enhanced_mode, .power_mode);

`default_nettype wire

/* serial_ctl.sv */
// Behavioural model of the controller driving the serial link
`default_nettype none

module serial_ctl (
  output logic serial_clk,
  output logic serial_data,
  output logic latch_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Frame driver, link clock idles low between frames
  // ----------------------------------------------------------------
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b1;
  end
  task automatic send(input logic [31:0] w, input int n);
    #1.3 latch_strobe = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_data = w[i];
      #62.5 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
    end
    latch_strobe = 1'b1;
    serial_data = ~serial_data;
    // Long gap so the strobe crossing settles
    #400;
  endtask
endmodule // serial_ctl

`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the serial programming port
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import synth_serial_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic main_sync = 1'b0;
  logic serial_clk, serial_data, latch_strobe, main_word_pending, ref_buffer_enable, transmit_if_synth_on;
  logic synth_shutdown, digital_cellular, analog_cellular, enhanced_mode;
  logic [3:0] main_ref_post_div, aux_ref_post_div, transmit_if_ratio;
  logic [TEST_W-1:0] test_route, t;
  main_div_s main_div;
  power_mode_e power_mode;
  pump_word_s pump_cfg, p, pw = PUMP_RESET;
  aux_word_s aux_cfg, x = AUX_RESET;
  ref_word_s ref_cfg, r = REF_RESET;
  general_word_s general_cfg, g = GEN_RESET;
  main_word_s m, mw = MAIN_RESET;
  int fails = 0;
  int samples_checked = 0;
  integer seed = 32'hee2782c2;

  always #4 clk_sys = ~clk_sys;
  synth_serial_program_port dut (.clk_sys, .rst, .clk_en, .serial_clk, .serial_data, .latch_strobe, .main_sync,
    .main_word_pending, .main_div, .pump_cfg, .aux_cfg, .ref_cfg, .general_cfg, .test_route, .ref_buffer_enable,
    .main_ref_post_div, .aux_ref_post_div, .transmit_if_ratio, .transmit_if_synth_on, .synth_shutdown, .digital_cellular,
    .analog_cellular, .enhanced_mode, .power_mode);
  serial_ctl ctl (.serial_clk, .serial_data, .latch_strobe);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic power_mode_e pm(logic [3:0] b);
    return b == 4'h0 ? PM_SLEEP : b == 4'hb ? PM_STANDBY : b == 4'hf ? PM_TRANSMIT : PM_OTHER;
  endfunction
  function automatic main_div_s md(main_word_s a, pump_word_s w);
    logic d;
    d = w.prescaler_select[0];
    return {d, a.main_first_cycle_count, d ? a.upper_counts : {4'h0, a.upper_counts[3:0]},
            d ? 4'h0 : a.upper_counts[7:4], a.fractional_increment, w.fraction_modulus_flag};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [19:0] d);
    ctl.send({8'h00, a, d}, 24);
    @(negedge clk_sys);
  endtask
  task automatic sync_pulse(input logic en);
    clk_en = en;
    main_sync = 1'b1;
    @(negedge clk_sys);
    clk_en = 1'b1;
    main_sync = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic chk_cfg();
    chk(general_cfg, g);
    chk(ref_cfg, r);
    chk(transmit_if_ratio, 4'h6 + g.transmit_if_div_select);
    chk({transmit_if_synth_on, synth_shutdown}, {g.transmit_if_loop_enable, !g.sleep_bit});
    chk({digital_cellular, analog_cellular}, {g.digital_cellular, !g.digital_cellular});
    chk(power_mode, pm({g.sleep_bit, g.transmit_if_loop_enable, r.aux_divider_enable, r.main_divider_enable}));
    chk(ref_buffer_enable, r.main_divider_enable | r.aux_divider_enable);
    chk({main_ref_post_div, aux_ref_post_div}, {4'h1 << r.main_ref_select, 4'h1 << r.aux_ref_select});
    chk({aux_cfg, enhanced_mode}, {x, x.enhanced_scheme_bit});
    chk(pump_cfg, pw);
    chk(main_div, md(mw, pw));
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #400000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk_cfg();
    chk({main_word_pending, test_route}, {1'b0, TEST_RESET});
    $display("test reset done");
    for (int k = 0; k < 5; k++) begin
      g = GEN_W'($random(seed));
      r = REF_W'($random(seed));
      x = AUX_W'($random(seed));
      p = PUMP_W'($random(seed));
      m = MAIN_W'($random(seed));
      t = TEST_W'($random(seed));
      p.prescaler_select[0] = k[0];
      // Sleep, standby and transmit corners first
      if (k < 3) begin
        {g.sleep_bit, g.transmit_if_loop_enable} = {k != 0, k == 2};
        {r.main_divider_enable, r.aux_divider_enable} = {k != 0, k != 0};
      end
      wr(ADDR_GENERAL, 20'(g));
      wr(ADDR_TEST, 20'(t));
      chk(test_route, t);
      wr(ADDR_REFERENCE, 20'(r));
      chk(test_route, TEST_RESET);
      wr(ADDR_AUXILIARY, 20'(x));
      wr(ADDR_PUMP, 20'(p));
      {pw.fraction_modulus_flag, pw.integral_accel_factor, pw.proportional_accel_factor} =
        {p.fraction_modulus_flag, p.integral_accel_factor, p.proportional_accel_factor};
      chk_cfg();
      ctl.send({8'h00, 1'b1, m}, 24);
      @(negedge clk_sys);
      chk_cfg();
      sync_pulse(1'b0);
      chk(main_word_pending, 1'b1);
      sync_pulse(1'b1);
      {mw, pw} = {m, p};
      chk(main_word_pending, 1'b0);
      chk_cfg();
      sync_pulse(1'b1);
      chk_cfg();
      $display("test word set %0d done", k);
    end
    for (int a = 5; a < 8; a++) begin
      wr(4'(a), 20'($random(seed)));
      chk_cfg();
      chk(test_route, TEST_RESET);
    end
    $display("test unmapped done");
    g = GEN_W'($random(seed));
    ctl.send({4'h0, ADDR_GENERAL, 20'(g), 4'h9}, 28);
    @(negedge clk_sys);
    chk_cfg();
    $display("test overlong done");
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
